// File: logic/gtdd_params.svh
`ifndef GTDD_PARAMS_SVH
`define GTDD_PARAMS_SVH

// module channel numbers; a channel's register sits at byte offset channel * 4
`define GTDD_CH_TOT          5
`define GTDD_CH_DAC_A        6
`define GTDD_CH_DAC_B        7

// register byte offsets
`define GTDD_ADDR_CTRL       8'h00
`define GTDD_ADDR_PORT0      8'h04
`define GTDD_ADDR_PORT1      8'h08
`define GTDD_ADDR_PORT2      8'h0C
`define GTDD_ADDR_PORT3      8'h10
`define GTDD_ADDR_TOT        8'h14
`define GTDD_ADDR_DAC_A      8'h18
`define GTDD_ADDR_DAC_B      8'h1C
`define GTDD_ADDR_PAIR_LO    8'h20
`define GTDD_ADDR_PAIR_HI    8'h24
`define GTDD_ADDR_WORD       8'h28
`define GTDD_ADDR_DIR        8'h2C
`define GTDD_ADDR_DAC_BOTH   8'h30

// control register fields
`define GTDD_CTRL_SLOPE      0
`define GTDD_CTRL_RTZ        1
`define GTDD_CTRL_CLEAR      2
`define GTDD_CTRL_MODRST     3

// reset values
`define GTDD_RST_DIR         4'h0
`define GTDD_RST_DIO_OUT     32'hFFFFFFFF
`define GTDD_RST_DAC         16'h8000

// analog request range, in volts and millivolts
`define GTDD_V_RANGE         12
`define GTDD_MV_PER_V        1000

`endif

// File: logic/gtdd_pkg.sv
package gtdd_pkg;

  typedef enum logic {
    GTDD_EDGE_RISE = 1'b0,
    GTDD_EDGE_FALL = 1'b1
  } gtdd_slope_t;

  typedef enum logic {
    GTDD_READ_KEEP = 1'b0,
    GTDD_READ_ZERO = 1'b1
  } gtdd_read_mode_t;

  typedef logic [15:0] gtdd_code_t;
  typedef logic [31:0] gtdd_word_t;

endpackage

// File: logic/gtdd_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module gtdd_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only; the filter looks at stages 2 and 3
  always_ff @(posedge mclk) begin
    stage1 <= async_in;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // gtdd_sync3

`default_nettype wire

// File: logic/gtdd_top.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`include "gtdd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gtdd_top #(
  parameter int PORTS = 4,
  parameter int PORT_W = 8
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // totalizer pins
  input  wire logic                  tot_count_pin,
  input  wire logic                  tot_gate_pin,
  input  wire logic                  tot_gate_n_pin,
  // digital port pins, open drain
  input  wire logic [PORTS*PORT_W-1:0] dio_pin_in,
  output logic      [PORTS*PORT_W-1:0] dio_pin_out,
  output logic      [PORTS*PORT_W-1:0] dio_pin_oe,
  // analog setpoints
  output gtdd_pkg::gtdd_code_t       dac_a_code,
  output gtdd_pkg::gtdd_code_t       dac_b_code
);
  import gtdd_pkg::*;

  localparam int DW = PORTS * PORT_W;
  localparam int MV_RANGE = `GTDD_V_RANGE * `GTDD_MV_PER_V;
  localparam logic [17:0] MV_SCALE = 18'((64'(16'hFFFF) << 16) / (2 * MV_RANGE));
  localparam logic [33:0] ROUND_HALF = 34'h000008000;

  // bus decode
  logic        setup_ph;
  logic        wr_acc;
  logic        rd_setup;
  logic        addr_hit;
  logic        soft_rst;
  logic        rst_all;

  // configuration
  gtdd_slope_t     slope;
  gtdd_read_mode_t read_mode;
  logic [PORTS-1:0] port_dir;
  logic [DW-1:0]    port_out;

  // totalizer
  logic [2:0]  pin_lvl;
  logic        cnt_lvl;
  logic        gate_lvl;
  logic        gate_n_lvl;
  logic        cnt_prev;
  logic        cnt_edge;
  logic        gates_open;
  logic        tally;
  logic [31:0] tot_count;
  logic        tot_clear;
  logic        tot_take;

  // digital ports
  logic [DW-1:0] dio_lvl;
  logic [DW-1:0] port_view;
  logic [DW-1:0] next_port_out;

  // analog
  gtdd_code_t req_code;
  logic [31:0] rd_mux;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = setup_ph & ~pwrite;
  assign rst_all  = sys_rst | soft_rst;

  // single-cycle access phase: read data is loaded during setup
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      `GTDD_ADDR_CTRL,  `GTDD_ADDR_PORT0,   `GTDD_ADDR_PORT1,
      `GTDD_ADDR_PORT2, `GTDD_ADDR_PORT3,   `GTDD_ADDR_TOT,
      `GTDD_ADDR_DAC_A, `GTDD_ADDR_DAC_B,   `GTDD_ADDR_PAIR_LO,
      `GTDD_ADDR_PAIR_HI, `GTDD_ADDR_WORD,  `GTDD_ADDR_DIR,
      `GTDD_ADDR_DAC_BOTH: addr_hit = 1'b1;
      default:             addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_hit;

  // soft reset lands one edge after the write so the bus write itself completes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_acc & (paddr == `GTDD_ADDR_CTRL) & pwdata[`GTDD_CTRL_MODRST];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      slope     <= GTDD_EDGE_RISE;
      read_mode <= GTDD_READ_KEEP;
    end else if (wr_acc && paddr == `GTDD_ADDR_CTRL) begin
      slope     <= gtdd_slope_t'(pwdata[`GTDD_CTRL_SLOPE]);
      read_mode <= gtdd_read_mode_t'(pwdata[`GTDD_CTRL_RTZ]);
    end
  end

  assign tot_clear = wr_acc & (paddr == `GTDD_ADDR_CTRL) & pwdata[`GTDD_CTRL_CLEAR];
  assign tot_take  = rd_setup & (paddr == `GTDD_ADDR_TOT) & (read_mode == GTDD_READ_ZERO);

  // pins pass four flops each (three stages and the filtered level) before any decision is made
  gtdd_sync3 #(
    .WIDTH (3)
  ) u_tot_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({tot_gate_n_pin, tot_gate_pin, tot_count_pin}),
    .level    (pin_lvl)
  );

  gtdd_sync3 #(
    .WIDTH (DW)
  ) u_dio_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (dio_pin_in),
    .level    (dio_lvl)
  );

  assign cnt_lvl    = pin_lvl[0];
  assign gate_lvl   = pin_lvl[1];
  assign gate_n_lvl = pin_lvl[2];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_prev <= 1'b0;
    end else begin
      cnt_prev <= cnt_lvl;
    end
  end

  assign cnt_edge = (slope == GTDD_EDGE_RISE) ? (cnt_lvl & ~cnt_prev) : (~cnt_lvl & cnt_prev);
  // undriven gate pins are pulled to their enabling level at the pad
  assign gates_open = gate_lvl & ~gate_n_lvl;
  // gates are sampled in the very cycle the edge is seen
  assign tally = cnt_edge & gates_open;

  // a clear or a zeroing read keeps an edge of the same cycle as count one
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      tot_count <= 32'h0;
    end else if (tot_clear) begin
      tot_count <= {31'h0, tally};
    end else if (tot_take) begin
      tot_count <= {31'h0, tally};
    end else if (tally) begin
      tot_count <= tot_count + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      port_dir <= `GTDD_RST_DIR;
    end else if (wr_acc && paddr == `GTDD_ADDR_DIR) begin
      port_dir <= pwdata[PORTS-1:0];
    end
  end

  // each access width writes its own lanes only
  always_comb begin
    next_port_out = port_out;
    if (wr_acc) begin
      case (paddr)
        `GTDD_ADDR_PORT0:   next_port_out[7:0]   = pwdata[7:0];
        `GTDD_ADDR_PORT1:   next_port_out[15:8]  = pwdata[7:0];
        `GTDD_ADDR_PORT2:   next_port_out[23:16] = pwdata[7:0];
        `GTDD_ADDR_PORT3:   next_port_out[31:24] = pwdata[7:0];
        `GTDD_ADDR_PAIR_LO: next_port_out[15:0]  = pwdata[15:0];
        `GTDD_ADDR_PAIR_HI: next_port_out[31:16] = pwdata[15:0];
        `GTDD_ADDR_WORD:    next_port_out        = pwdata;
        default:            next_port_out        = port_out;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      port_out <= `GTDD_RST_DIO_OUT;
    end else begin
      port_out <= next_port_out;
    end
  end

  // open drain: only a zero in an output port pulls the pin
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      dio_pin_oe <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        dio_pin_oe[p*PORT_W +: PORT_W] <= {PORT_W{port_dir[p]}} & ~next_port_out[p*PORT_W +: PORT_W];
      end
    end
  end

  assign dio_pin_out = '0;

  // output ports read back the latch, not the pin, so a slow pull-up cannot show
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      port_view[p*PORT_W +: PORT_W] = port_dir[p] ? port_out[p*PORT_W +: PORT_W]
                                                  : dio_lvl[p*PORT_W +: PORT_W];
    end
  end

  // millivolt request, clamped to the range, scaled to full-scale code with rounding
  function automatic gtdd_code_t volts_to_code(input logic [31:0] mv);
    logic signed [31:0] smv;
    logic [14:0]        ofs;
    logic [33:0]        prod;
    smv = signed'(mv);
    if (smv > MV_RANGE) begin
      ofs = 15'(2 * MV_RANGE);
    end else if (smv < -MV_RANGE) begin
      ofs = 15'h0;
    end else begin
      ofs = 15'(smv + MV_RANGE);
    end
    prod = 34'(ofs) * 34'(MV_SCALE) + ROUND_HALF;
    return prod[31:16];
  endfunction

  assign req_code = volts_to_code(pwdata);

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      dac_a_code <= `GTDD_RST_DAC;
    end else if (wr_acc && (paddr == `GTDD_ADDR_DAC_A || paddr == `GTDD_ADDR_DAC_BOTH)) begin
      dac_a_code <= req_code;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      dac_b_code <= `GTDD_RST_DAC;
    end else if (wr_acc && (paddr == `GTDD_ADDR_DAC_B || paddr == `GTDD_ADDR_DAC_BOTH)) begin
      dac_b_code <= req_code;
    end
  end

  always_comb begin
    case (paddr)
      `GTDD_ADDR_CTRL:    rd_mux = {30'h0, read_mode, slope};
      `GTDD_ADDR_PORT0:   rd_mux = {24'h0, port_view[7:0]};
      `GTDD_ADDR_PORT1:   rd_mux = {24'h0, port_view[15:8]};
      `GTDD_ADDR_PORT2:   rd_mux = {24'h0, port_view[23:16]};
      `GTDD_ADDR_PORT3:   rd_mux = {24'h0, port_view[31:24]};
      `GTDD_ADDR_TOT:     rd_mux = tot_count;
      `GTDD_ADDR_DAC_A:   rd_mux = {16'h0, dac_a_code};
      `GTDD_ADDR_DAC_B:   rd_mux = {16'h0, dac_b_code};
      `GTDD_ADDR_PAIR_LO: rd_mux = {16'h0, port_view[15:0]};
      `GTDD_ADDR_PAIR_HI: rd_mux = {16'h0, port_view[31:16]};
      `GTDD_ADDR_WORD:    rd_mux = port_view;
      `GTDD_ADDR_DIR:     rd_mux = {28'h0, port_dir};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_tot_counts_edge: assert property (
    (!soft_rst && !tot_clear && !tot_take && tally) |=> tot_count == $past(tot_count) + 32'h1
  ) else $error("gated edge not counted");

  a_gate_blocks_count: assert property (
    (!gate_lvl || gate_n_lvl) && !soft_rst && !tot_clear && !tot_take |=> $stable(tot_count)
  ) else $error("count moved with a gate closed");

  a_fall_slope_edge: assert property (
    (slope == GTDD_EDGE_FALL) && $fell(cnt_lvl) ##0 gates_open |-> tally
  ) else $error("falling edge missed in fall mode");

  a_rise_slope_quiet: assert property (
    (slope == GTDD_EDGE_RISE) && $fell(cnt_lvl) |-> !tally
  ) else $error("falling edge counted in rise mode");

  a_keep_read_holds: assert property (
    rd_setup && paddr == `GTDD_ADDR_TOT && read_mode == GTDD_READ_KEEP && !tally && !tot_clear && !soft_rst
    |=> tot_count == $past(tot_count) && prdata == $past(tot_count)
  ) else $error("keep-mode read disturbed the count");

  a_zero_read_clears: assert property (
    tot_take && !soft_rst |=> tot_count == {31'h0, $past(tally)} && prdata == $past(tot_count)
  ) else $error("zeroing read lost data or an edge");

  a_clear_zeroes: assert property (
    tot_clear && !soft_rst |=> tot_count == {31'h0, $past(tally)}
  ) else $error("clear did not zero the count");

  a_count_wraps: assert property (
    tot_count == 32'hFFFFFFFF && tally && !tot_clear && !tot_take && !soft_rst |=> tot_count == 32'h0
  ) else $error("count did not wrap");

  a_read_keeps_dir: assert property (
    psel && !pwrite && !soft_rst |=> $stable(port_dir)
  ) else $error("read changed port direction");

  a_out_port_view: assert property (
    rd_setup && paddr == `GTDD_ADDR_PORT0 && port_dir[0] |=> prdata[7:0] == $past(port_out[7:0])
  ) else $error("output port reads pins");

  a_dac_both_write: assert property (
    wr_acc && paddr == `GTDD_ADDR_DAC_BOTH && !soft_rst |=> dac_a_code == dac_b_code
  ) else $error("dual analog write split");

  a_modrst_defaults: assert property (
    soft_rst |=> port_dir == `GTDD_RST_DIR && dac_a_code == `GTDD_RST_DAC && tot_count == 32'h0
  ) else $error("module reset left state behind");

endmodule // gtdd_top

`default_nettype wire

// File: dv/gtdd_field.sv
`timescale 1ns/1ps
`default_nettype none

module gtdd_field (
  // clock
  input  wire logic        mclk,
  // pulse source control
  input  wire logic        start,
  input  wire logic [7:0]  n_pulses,
  input  wire logic        flip,
  output logic             busy,
  output logic             tot_count_pin,
  // external drive on the digital pins
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  input  wire logic [31:0] dio_pin_oe,
  output logic      [31:0] dio_pin_in
);
  logic [8:0] edges_left = 9'h000;
  logic [2:0] tick       = 3'h0;
  logic       gen        = 1'b0;

  // six clocks per half period keeps every level well past the input filter
  always_ff @(posedge mclk) begin
    if (start) begin
      edges_left <= {n_pulses, 1'b0};
      tick       <= 3'h0;
    end else if (edges_left != 9'h000) begin
      if (tick == 3'h5) begin
        tick       <= 3'h0;
        gen        <= ~gen;
        edges_left <= edges_left - 9'h001;
      end else begin
        tick <= tick + 3'h1;
      end
    end
  end

  assign busy          = (edges_left != 9'h000);
  assign tot_count_pin = gen ^ flip;
  // open drain wire: device pulls low, otherwise external driver or pull-up
  assign dio_pin_in    = ~dio_pin_oe & ((ext_en & ext_val) | ~ext_en);
endmodule // gtdd_field

`default_nettype wire

// File: dv/test_gated_totalizer_dio_dac_module.sv
`include "gtdd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_gated_totalizer_dio_dac_module;
  import gtdd_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, npulse;
  logic [31:0] pwdata, prdata, dio_pin_in, dio_pin_oe, dio_pin_out, ext_en, ext_val, r, acc;
  logic        gate, gate_n, cnt_pin, start, flip, busy, e;
  gtdd_code_t  dac_a_code, dac_b_code;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          mvs[5] = '{-12000, 12000, 0, 20000, -1};

  always #4 mclk = ~mclk;

  gtdd_top i_gtdd_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tot_count_pin(cnt_pin), .tot_gate_pin(gate), .tot_gate_n_pin(gate_n), .dio_pin_in(dio_pin_in),
    .dio_pin_out(dio_pin_out), .dio_pin_oe(dio_pin_oe), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));

  gtdd_field i_gtdd_field (.mclk(mclk), .start(start), .n_pulses(npulse), .flip(flip), .busy(busy),
    .tot_count_pin(cnt_pin), .ext_en(ext_en), .ext_val(ext_val), .dio_pin_oe(dio_pin_oe),
    .dio_pin_in(dio_pin_in));

  function automatic logic [31:0] conv(input int mv);
    longint m;
    m = (mv < -12000) ? -12000 : ((mv > 12000) ? 12000 : mv);
    return {16'h0000, 16'(((m + 12000) * 178954 + 32768) >>> 16)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // registered outputs only show the write one edge after it lands
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(r, exp, "read");
  endtask

  task automatic burst(input logic [7:0] n);
    @(posedge mclk);
    start  <= 1'b1;
    npulse <= n;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    while (busy === 1'b1) begin
      @(posedge mclk);
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic defaults();
    rd(`GTDD_ADDR_CTRL, 32'h00000000);
    rd(`GTDD_ADDR_DIR, 32'h00000000);
    rd(`GTDD_ADDR_DAC_A, 32'h00008000);
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    chk({dac_b_code, dac_a_code}, 32'h80008000, "dac");
    chk(dio_pin_oe, 32'h00000000, "oe");
    chk(dio_pin_out, 32'h00000000, "drive level");
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    {sys_rst, gate, gate_n, psel, penable, pwrite, start, flip} = 8'hC0;
    {paddr, npulse, pwdata, ext_en, ext_val} = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    defaults();
    // unwired gates: true gate pulled high, inverted gate low
    burst(8'h05);
    rd(8'(`GTDD_CH_TOT * 4), 32'h00000005);
    rd(`GTDD_ADDR_TOT, 32'h00000005);
    gate <= 1'b0;
    burst(8'h03);
    rd(`GTDD_ADDR_TOT, 32'h00000005);
    gate   <= 1'b1;
    gate_n <= 1'b1;
    burst(8'h03);
    rd(`GTDD_ADDR_TOT, 32'h00000005);
    gate_n <= 1'b0;
    burst(8'h02);
    rd(`GTDD_ADDR_TOT, 32'h00000007);
    wr(`GTDD_ADDR_CTRL, 32'h00000005);
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    flip <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    flip <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(`GTDD_ADDR_TOT, 32'h00000001);
    rd(`GTDD_ADDR_CTRL, 32'h00000001);
    wr(`GTDD_ADDR_CTRL, 32'h00000002);
    burst(8'h04);
    rd(`GTDD_ADDR_TOT, 32'h00000005);
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    // reads every 5 clocks against edges every 12: some read meets an edge in its setup cycle
    acc = 32'h00000000;
    fork
      burst(8'h06);
      repeat (18) begin
        apb(1'b0, `GTDD_ADDR_TOT, 32'h00000000);
        acc = acc + r;
        repeat (2) @(posedge mclk);
      end
    join
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    chk(acc, 32'h00000006, "zeroing reads sum");
    burst(8'h02);
    wr(`GTDD_ADDR_CTRL, 32'h00000006);
    rd(`GTDD_ADDR_TOT, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    chk({r[30:0], e}, 32'h00000001, "unmapped read");
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    chk({31'h0, e}, 32'h00000001, "unmapped write");
    wr(`GTDD_ADDR_DIR, 32'h00000001);
    wr(`GTDD_ADDR_PORT0, 32'h00000040);
    chk(dio_pin_oe, 32'h000000BF, "oe port0");
    rd(`GTDD_ADDR_PORT0, 32'h00000040);
    rd(`GTDD_ADDR_PORT0, 32'h00000040);
    rd(`GTDD_ADDR_DIR, 32'h00000001);
    wr(`GTDD_ADDR_DIR, 32'h00000000);
    ext_en  <= 32'h000000FF;
    ext_val <= 32'h0000005A;
    repeat (6) @(posedge mclk);
    rd(`GTDD_ADDR_PORT0, 32'h0000005A);
    ext_en <= 32'h00000000;
    wr(`GTDD_ADDR_DIR, 32'h0000000F);
    wr(`GTDD_ADDR_WORD, 32'h12345678);
    chk(dio_pin_oe, 32'hEDCBA987, "oe word");
    rd(`GTDD_ADDR_PAIR_LO, 32'h00005678);
    rd(`GTDD_ADDR_PAIR_HI, 32'h00001234);
    rd(`GTDD_ADDR_PORT3, 32'h00000012);
    wr(`GTDD_ADDR_PAIR_HI, 32'h0000ABCD);
    rd(`GTDD_ADDR_WORD, 32'hABCD5678);
    foreach (mvs[i]) begin
      wr(`GTDD_ADDR_DAC_A, 32'(mvs[i]));
      wr(`GTDD_ADDR_DAC_B, 32'(-mvs[i]));
      chk({16'h0000, dac_a_code}, conv(mvs[i]), "dac a");
      chk({16'h0000, dac_b_code}, conv(-mvs[i]), "dac b");
      rd(`GTDD_ADDR_DAC_A, conv(mvs[i]));
    end
    wr(`GTDD_ADDR_DAC_BOTH, 32'h000009C4);
    chk({dac_b_code, dac_a_code}, (conv(2500) << 16) | conv(2500), "dac both");
    wr(`GTDD_ADDR_CTRL, 32'h00000008);
    defaults();
    final_report();
  end
endmodule // test_gated_totalizer_dio_dac_module

`default_nettype wire
